/* rtl/spfm_top.sv */
// Operation
// - Sample strap pins at reset, set modes
// - Capture strap after delay, not at edge
// - After capture strap pins become general I/O
// - Pulls enabled on strap pins while sampling
// - Voltage strap pulled high; 1 = 1.8V
// - Host strap pulled low; high selects SDIO
// - Each pad has its own independent select
// - Select 0 gives aux pads plain I/O
// - Serial pads: 0 serial, 7 general I/O
// - Voice pads: I/O, voice, audio, flash
// - Aux pads 5..2: I/O, audio; aux 5 also clock request
// - Clock request pad: 0 request, 7 I/O
// - Voice sync/clock out as master, in slave
// - Audio master drives clocks; slave receives them
// - Flash master drives clock, data, select
// - Priority status output to coexistence partner
// - Radio active high during receive/transmit slots
// - Group-A I/O via serial CTS/RTS, voice, audio data and clock request pads
module spfm_top
  import spfm_pkg::*;
#(
  parameter int STRAP_DELAY_CYCLES = STRAP_DELAY_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ext_por_n_i,
  input wire logic [SPFM_NUM_STRAPS-1:0] strap_pad_in_i,
  input wire logic [SPFM_NUM_PADS-1:0] pad_in_i,
  input wire logic [SPFM_NUM_PADS-1:0][SPFM_SEL_W-1:0] pad_sel_i,
  input wire spfm_core_out_t core_out_i,
  output logic [SPFM_NUM_STRAPS-1:0] strap_pad_out_o,
  output logic [SPFM_NUM_STRAPS-1:0] strap_pad_oe_n_o,
  output logic [SPFM_NUM_STRAPS-1:0] strap_pull_up_o,
  output logic [SPFM_NUM_STRAPS-1:0] strap_pull_down_o,
  output logic strap_done_o,
  output logic sdio_pad_1v8_o,
  output logic host_sdio_sel_o,
  output logic [SPFM_NUM_PADS-1:0] pad_out_o,
  output logic [SPFM_NUM_PADS-1:0] pad_oe_n_o,
  output spfm_core_in_t core_in_o,
  output logic coex_radio_active_o
);

  localparam int CNT_W = $clog2(STRAP_DELAY_CYCLES + 1);
  localparam int SYNC_W = SPFM_NUM_PADS + SPFM_NUM_STRAPS + 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STRAP_DELAY_CYCLES - 1);

  spfm_state_t state;
  spfm_state_t next_state;
  logic [CNT_W-1:0] delay_cnt;
  logic [SYNC_W-1:0] sync_bus;
  logic [SPFM_NUM_PADS-1:0] pad_s;
  logic [SPFM_NUM_STRAPS-1:0] strap_s;
  logic ext_por_n_s;
  spfm_pad_fn_t [SPFM_NUM_PADS-1:0] next_fn;
  spfm_core_in_t next_core_in;

  // ****************************************
  // Input synchronisers
  // ****************************************
  spfm_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys_i,
    .resetn_i,
    .async_i({ext_por_n_i, strap_pad_in_i, pad_in_i}),
    .sync_o(sync_bus)
  );

  assign pad_s = sync_bus[SPFM_NUM_PADS-1:0];
  assign strap_s = sync_bus[SPFM_NUM_PADS +: SPFM_NUM_STRAPS];
  assign ext_por_n_s = sync_bus[SYNC_W-1];

  // ****************************************
  // Strap sequencing
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_POR:
      begin
        if (ext_por_n_s)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (delay_cnt == CNT_LAST)
          next_state = ST_CAPTURE;
      end
      ST_CAPTURE:
        next_state = ST_RUN;
      ST_RUN:
        next_state = ST_RUN;
      default:
        next_state = ST_POR;
    endcase
    // External reset input restarts the whole strap sequence
    if (!ext_por_n_s)
      next_state = ST_POR;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      state <= ST_POR;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      delay_cnt <= '0;
    else if (state == ST_WAIT)
      delay_cnt <= delay_cnt + CNT_W'(1);
    else
      delay_cnt <= '0;
  end

  // Latched values change only in CAPTURE, so later pad activity cannot disturb them
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      sdio_pad_1v8_o <= STRAP_VSEL_DEFAULT;
      host_sdio_sel_o <= STRAP_HOST_DEFAULT;
    end
    else if (state == ST_CAPTURE)
    begin
      sdio_pad_1v8_o <= strap_s[STRAP_VSEL];
      host_sdio_sel_o <= strap_s[STRAP_HOST];
    end
  end

  // Pulls stay on until capture so an undriven strap reads its default
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      strap_done_o <= 1'h0;
      strap_pad_out_o <= '0;
      strap_pad_oe_n_o <= '1;
      strap_pull_up_o <= STRAP_PULL_UP;
      strap_pull_down_o <= STRAP_PULL_DN;
    end
    else if (next_state == ST_RUN)
    begin
      strap_done_o <= 1'h1;
      strap_pad_out_o <= core_out_i.strap_gpio_o;
      strap_pad_oe_n_o <= core_out_i.strap_gpio_oe_n;
      strap_pull_up_o <= '0;
      strap_pull_down_o <= '0;
    end
    else
    begin
      strap_done_o <= 1'h0;
      strap_pad_out_o <= '0;
      strap_pad_oe_n_o <= '1;
      strap_pull_up_o <= STRAP_PULL_UP;
      strap_pull_down_o <= STRAP_PULL_DN;
    end
  end

  // ****************************************
  // Pad function decode
  // ****************************************
  function automatic spfm_pad_fn_t drv(input logic val);
    drv = '{out: val, oe_n: 1'h0, role: RL_NONE, idx: GIDX_0};
  endfunction

  function automatic spfm_pad_fn_t rcv(input spfm_role_t role);
    rcv = '{out: 1'h0, oe_n: 1'h1, role: role, idx: GIDX_0};
  endfunction

  function automatic spfm_pad_fn_t gio(input logic [7:0] o, input logic [7:0] oe_n,
                                       input spfm_role_t role, input logic [2:0] i);
    gio = '{out: o[i], oe_n: oe_n[i], role: role, idx: i};
  endfunction

  // Voice sync and clock turn around with the master/slave choice
  function automatic spfm_pad_fn_t vio(input logic val, input logic master,
                                       input spfm_role_t role);
    vio = '{out: val, oe_n: !master, role: master ? RL_NONE : role, idx: GIDX_0};
  endfunction

  function automatic spfm_pad_fn_t pad_map(input int pin, input logic [3:0] sel,
                                           input spfm_core_out_t c);
    spfm_pad_fn_t f;
    logic [7:0] g;
    logic [7:0] gn;
    logic [7:0] a;
    logic [7:0] an;
    f = rcv(RL_NONE);
    g = c.gpio_o;
    gn = c.gpio_oe_n;
    a = c.agpio_o;
    an = c.agpio_oe_n;
    case (pin)
      PAD_SERIAL_CTS:
        case (sel)
          SEL_BASE: f = rcv(RL_CTS);
          SEL_ALT_7: f = gio(a, an, RL_AGPIO, GIDX_1);
          default: f = rcv(RL_NONE);
        endcase
      PAD_SERIAL_RTS:
        case (sel)
          SEL_BASE: f = drv(c.serial_rts_n);
          SEL_ALT_7: f = gio(a, an, RL_AGPIO, GIDX_0);
          default: f = rcv(RL_NONE);
        endcase
      PAD_SERIAL_RX:
        case (sel)
          SEL_BASE: f = rcv(RL_RXD);
          SEL_ALT_7: f = gio(g, gn, RL_GPIO, GIDX_5);
          default: f = rcv(RL_NONE);
        endcase
      PAD_SERIAL_TX:
        case (sel)
          SEL_BASE: f = drv(c.serial_tx);
          SEL_ALT_7: f = gio(g, gn, RL_GPIO, GIDX_4);
          default: f = rcv(RL_NONE);
        endcase
      PAD_VOICE_DIN:
        case (sel)
          SEL_BASE: f = gio(a, an, RL_AGPIO, GIDX_3);
          SEL_VOICE_A, SEL_VOICE_B: f = rcv(RL_VOICE_IN);
          SEL_ALT_3: f = drv(c.host_clock);
          SEL_ALT_7: f = rcv(RL_AUDIO_IN);
          SEL_FLASH: f = rcv(RL_FLASH_IN);
          default: f = rcv(RL_NONE);
        endcase
      PAD_VOICE_DOUT:
        case (sel)
          SEL_BASE: f = gio(a, an, RL_AGPIO, GIDX_2);
          SEL_VOICE_A, SEL_VOICE_B: f = drv(c.voice_out);
          SEL_ALT_3: f = drv(c.link_indicator);
          SEL_AUDIO_MASTER: f = drv(c.audio_master_data_out);
          SEL_ALT_7: f = drv(c.audio_slave_data_out);
          SEL_FLASH: f = drv(c.flash_data_out);
          default: f = rcv(RL_NONE);
        endcase
      PAD_VOICE_SYNC:
        case (sel)
          SEL_BASE: f = gio(a, an, RL_AGPIO, GIDX_1);
          SEL_VOICE_A, SEL_VOICE_B: f = vio(c.voice_sync, c.voice_master, RL_VOICE_SYNC);
          SEL_ALT_3: f = drv(c.host_clock);
          SEL_AUDIO_MASTER: f = drv(c.audio_master_word_select);
          SEL_ALT_7: f = rcv(RL_SLAVE_WS);
          SEL_FLASH: f = drv(c.flash_chip_select_n);
          default: f = rcv(RL_NONE);
        endcase
      PAD_VOICE_CLK:
        case (sel)
          SEL_BASE: f = gio(a, an, RL_AGPIO, GIDX_0);
          SEL_VOICE_A, SEL_VOICE_B: f = vio(c.voice_clk, c.voice_master, RL_VOICE_CLK);
          SEL_AUDIO_MASTER: f = drv(c.audio_master_bit_clock);
          SEL_ALT_7: f = rcv(RL_SLAVE_CLK);
          SEL_FLASH: f = drv(c.flash_serial_clock);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUDIO_DOUT:
        case (sel)
          SEL_BASE: f = gio(a, an, RL_AGPIO, GIDX_5);
          SEL_VOICE_A: f = drv(c.voice_out);
          SEL_ALT_4: f = drv(c.audio_slave_data_out);
          SEL_AUDIO_MASTER: f = drv(c.audio_master_data_out);
          SEL_ALT_7: f = drv(c.prio_status);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUDIO_DIN:
        case (sel)
          SEL_BASE: f = gio(a, an, RL_AGPIO, GIDX_6);
          SEL_VOICE_A: f = rcv(RL_VOICE_IN);
          SEL_ALT_3: f = drv(c.host_clock);
          SEL_ALT_4: f = rcv(RL_AUDIO_IN);
          SEL_ALT_7: f = rcv(RL_GRANT);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUDIO_WS:
        case (sel)
          SEL_BASE: f = gio(g, gn, RL_GPIO, GIDX_7);
          SEL_VOICE_A: f = vio(c.voice_sync, c.voice_master, RL_VOICE_SYNC);
          SEL_ALT_3: f = drv(c.link_indicator);
          SEL_AUDIO_MASTER: f = drv(c.audio_master_word_select);
          SEL_ALT_7: f = rcv(RL_SLAVE_WS);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUDIO_CLK:
        case (sel)
          SEL_BASE: f = gio(g, gn, RL_GPIO, GIDX_6);
          SEL_VOICE_A: f = vio(c.voice_clk, c.voice_master, RL_VOICE_CLK);
          SEL_ALT_4: f = drv(c.low_power_clock_out);
          SEL_AUDIO_MASTER: f = drv(c.audio_master_bit_clock);
          SEL_ALT_7: f = rcv(RL_SLAVE_CLK);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUX_5:
        case (sel)
          SEL_BASE: f = gio(g, gn, RL_GPIO, GIDX_5);
          SEL_VOICE_A: f = drv(c.host_clock);
          SEL_ALT_3: f = drv(c.audio_master_bit_clock);
          SEL_ALT_4: f = rcv(RL_SLAVE_CLK);
          SEL_ALT_7: f = drv(c.shared_clock_request);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUX_4:
        case (sel)
          SEL_BASE: f = gio(g, gn, RL_GPIO, GIDX_4);
          SEL_VOICE_A: f = drv(c.link_indicator);
          SEL_ALT_3: f = drv(c.audio_master_data_out);
          SEL_ALT_4: f = drv(c.audio_slave_data_out);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUX_3:
        case (sel)
          SEL_BASE: f = gio(g, gn, RL_GPIO, GIDX_3);
          SEL_ALT_3: f = drv(c.audio_master_word_select);
          SEL_ALT_4: f = rcv(RL_SLAVE_WS);
          default: f = rcv(RL_NONE);
        endcase
      PAD_AUX_2:
        case (sel)
          SEL_BASE: f = gio(g, gn, RL_GPIO, GIDX_2);
          SEL_ALT_4: f = rcv(RL_AUDIO_IN);
          default: f = rcv(RL_NONE);
        endcase
      PAD_CLOCK_REQ:
        case (sel)
          SEL_BASE: f = drv(c.shared_clock_request);
          SEL_ALT_7: f = gio(a, an, RL_AGPIO, GIDX_7);
          default: f = rcv(RL_NONE);
        endcase
      default: f = rcv(RL_NONE);
    endcase
    return f;
  endfunction

  always_comb
  begin
    for (int p = 0; p < SPFM_NUM_PADS; p++)
      next_fn[p] = pad_map(p, pad_sel_i[p], core_out_i);
  end

  // ****************************************
  // Input routing
  // ****************************************
  // Two pads claiming one input: the lowest-numbered pad wins
  always_comb
  begin
    next_core_in = CORE_IN_IDLE;
    next_core_in.strap_gpio_i = strap_done_o ? strap_s : '0;
    for (int p = SPFM_NUM_PADS - 1; p >= 0; p--)
    begin
      case (next_fn[p].role)
        RL_CTS: next_core_in.serial_cts_n = pad_s[p];
        RL_RXD: next_core_in.serial_rx = pad_s[p];
        RL_VOICE_IN: next_core_in.voice_in = pad_s[p];
        RL_VOICE_SYNC: next_core_in.voice_sync = pad_s[p];
        RL_VOICE_CLK: next_core_in.voice_clk = pad_s[p];
        RL_SLAVE_CLK: next_core_in.audio_slave_bit_clock = pad_s[p];
        RL_SLAVE_WS: next_core_in.audio_slave_word_select = pad_s[p];
        RL_AUDIO_IN: next_core_in.audio_shared_data_in = pad_s[p];
        RL_GRANT: next_core_in.coex_transmit_grant = pad_s[p];
        RL_FLASH_IN: next_core_in.flash_data_in = pad_s[p];
        RL_GPIO: next_core_in.gpio_i[next_fn[p].idx] = pad_s[p];
        RL_AGPIO: next_core_in.agpio_i[next_fn[p].idx] = pad_s[p];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Registered pad and core outputs
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      pad_out_o <= '0;
      pad_oe_n_o <= '1;
    end
    else
    begin
      for (int p = 0; p < SPFM_NUM_PADS; p++)
      begin
        pad_out_o[p] <= next_fn[p].out;
        pad_oe_n_o[p] <= next_fn[p].oe_n;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      core_in_o <= CORE_IN_IDLE;
    else
      core_in_o <= next_core_in;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      coex_radio_active_o <= 1'h0;
    else
      coex_radio_active_o <= core_out_i.radio_rx_slot | core_out_i.radio_tx_slot;
  end

endmodule

/* rtl/spfm_pkg.sv */
package spfm_pkg;

  // ****************************************
  // Pad indices and selects
  // ****************************************
  localparam int SPFM_NUM_PADS = 17;
  localparam int SPFM_SEL_W = 4;
  localparam int SPFM_GPIO_W = 8;
  localparam int SPFM_NUM_STRAPS = 2;

  localparam int PAD_SERIAL_CTS = 0;
  localparam int PAD_SERIAL_RTS = 1;
  localparam int PAD_SERIAL_RX = 2;
  localparam int PAD_SERIAL_TX = 3;
  localparam int PAD_VOICE_DIN = 4;
  localparam int PAD_VOICE_DOUT = 5;
  localparam int PAD_VOICE_SYNC = 6;
  localparam int PAD_VOICE_CLK = 7;
  localparam int PAD_AUDIO_DOUT = 8;
  localparam int PAD_AUDIO_DIN = 9;
  localparam int PAD_AUDIO_WS = 10;
  localparam int PAD_AUDIO_CLK = 11;
  localparam int PAD_AUX_5 = 12;
  localparam int PAD_AUX_4 = 13;
  localparam int PAD_AUX_3 = 14;
  localparam int PAD_AUX_2 = 15;
  localparam int PAD_CLOCK_REQ = 16;

  localparam logic [3:0] SEL_BASE = 4'h0;
  localparam logic [3:0] SEL_VOICE_A = 4'h1;
  localparam logic [3:0] SEL_VOICE_B = 4'h2;
  localparam logic [3:0] SEL_ALT_3 = 4'h3;
  localparam logic [3:0] SEL_ALT_4 = 4'h4;
  localparam logic [3:0] SEL_AUDIO_MASTER = 4'h5;
  localparam logic [3:0] SEL_ALT_7 = 4'h7;
  localparam logic [3:0] SEL_FLASH = 4'hf;

  localparam logic [2:0] GIDX_0 = 3'h0;
  localparam logic [2:0] GIDX_1 = 3'h1;
  localparam logic [2:0] GIDX_2 = 3'h2;
  localparam logic [2:0] GIDX_3 = 3'h3;
  localparam logic [2:0] GIDX_4 = 3'h4;
  localparam logic [2:0] GIDX_5 = 3'h5;
  localparam logic [2:0] GIDX_6 = 3'h6;
  localparam logic [2:0] GIDX_7 = 3'h7;

  // ****************************************
  // Straps and timing
  // ****************************************
  localparam int STRAP_VSEL = 0;
  localparam int STRAP_HOST = 1;
  localparam logic [1:0] STRAP_PULL_UP = 2'h1;
  localparam logic [1:0] STRAP_PULL_DN = 2'h2;
  localparam logic STRAP_VSEL_DEFAULT = 1'h1;
  localparam logic STRAP_HOST_DEFAULT = 1'h0;
  localparam int STRAP_DELAY_US = 2000;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int STRAP_DELAY_CYCLES_DEF = STRAP_DELAY_US * CLK_FREQ_MHZ;

  typedef enum logic [1:0] {
    ST_POR = 2'h0,
    ST_WAIT = 2'h1,
    ST_CAPTURE = 2'h3,
    ST_RUN = 2'h2
  } spfm_state_t;

  typedef enum logic [3:0] {
    RL_NONE = 4'h0,
    RL_CTS = 4'h1,
    RL_RXD = 4'h2,
    RL_VOICE_IN = 4'h3,
    RL_VOICE_SYNC = 4'h4,
    RL_VOICE_CLK = 4'h5,
    RL_SLAVE_CLK = 4'h6,
    RL_SLAVE_WS = 4'h7,
    RL_AUDIO_IN = 4'h8,
    RL_GRANT = 4'h9,
    RL_FLASH_IN = 4'ha,
    RL_GPIO = 4'hb,
    RL_AGPIO = 4'hc
  } spfm_role_t;

  typedef struct packed {
    logic out;
    logic oe_n;
    spfm_role_t role;
    logic [2:0] idx;
  } spfm_pad_fn_t;

  typedef struct packed {
    logic [7:0] gpio_o;
    logic [7:0] gpio_oe_n;
    logic [7:0] agpio_o;
    logic [7:0] agpio_oe_n;
    logic [1:0] strap_gpio_o;
    logic [1:0] strap_gpio_oe_n;
    logic serial_rts_n;
    logic serial_tx;
    logic voice_out;
    logic voice_sync;
    logic voice_clk;
    logic voice_master;
    logic audio_master_data_out;
    logic audio_master_word_select;
    logic audio_master_bit_clock;
    logic audio_slave_data_out;
    logic prio_status;
    logic link_indicator;
    logic host_clock;
    logic low_power_clock_out;
    logic shared_clock_request;
    logic flash_serial_clock;
    logic flash_data_out;
    logic flash_chip_select_n;
    logic radio_rx_slot;
    logic radio_tx_slot;
  } spfm_core_out_t;

  typedef struct packed {
    logic [7:0] gpio_i;
    logic [7:0] agpio_i;
    logic [1:0] strap_gpio_i;
    logic serial_cts_n;
    logic serial_rx;
    logic voice_in;
    logic voice_sync;
    logic voice_clk;
    logic audio_slave_bit_clock;
    logic audio_slave_word_select;
    logic audio_shared_data_in;
    logic coex_transmit_grant;
    logic flash_data_in;
  } spfm_core_in_t;

  // Idle levels when no pad carries the function: serial idles high, no grant
  localparam spfm_core_in_t CORE_IN_IDLE = '{
    gpio_i: 8'h00, agpio_i: 8'h00, strap_gpio_i: 2'h0,
    serial_cts_n: 1'h1, serial_rx: 1'h1, voice_in: 1'h0, voice_sync: 1'h0,
    voice_clk: 1'h0, audio_slave_bit_clock: 1'h0, audio_slave_word_select: 1'h0,
    audio_shared_data_in: 1'h0, coex_transmit_grant: 1'h0, flash_data_in: 1'h0};

endpackage

/* rtl/spfm_sync.sv */
module spfm_sync
  import spfm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

/* tb/spfm_board.sv */
module spfm_board
  import spfm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [SPFM_NUM_PADS-1:0] pad_out_i,
  input wire logic [SPFM_NUM_PADS-1:0] pad_oe_n_i,
  input wire logic [SPFM_NUM_PADS-1:0] ext_en_i,
  input wire logic [SPFM_NUM_PADS-1:0] ext_val_i,
  input wire logic [1:0] strap_out_i,
  input wire logic [1:0] strap_oe_n_i,
  input wire logic [1:0] pull_up_i,
  input wire logic [1:0] pull_dn_i,
  input wire logic [1:0] strap_en_i,
  input wire logic [1:0] strap_val_i,
  output logic [SPFM_NUM_PADS-1:0] pad_lvl_o,
  output logic [1:0] strap_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven lines toggle so stale levels never pass
  logic float_q = 1'h0;
  always_ff @(posedge clk_sys_i)
    float_q <= !float_q;
  always_comb
  begin
    for (int i = 0; i < SPFM_NUM_PADS; i++)
      pad_lvl_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] : float_q;
    for (int i = 0; i < 2; i++)
      strap_lvl_o[i] = !strap_oe_n_i[i] ? strap_out_i[i] : strap_en_i[i] ? strap_val_i[i] :
        pull_up_i[i] ? 1'h1 : pull_dn_i[i] ? 1'h0 : float_q;
  end
endmodule

/* tb/spfm_top_assertions.sv */
module spfm_top_checker
  import spfm_pkg::*;
#(
  parameter int STRAP_DELAY_CYCLES = STRAP_DELAY_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ext_por_n_i,
  input wire logic [SPFM_NUM_PADS-1:0][SPFM_SEL_W-1:0] pad_sel_i,
  input wire spfm_core_out_t core_out_i,
  input wire logic [SPFM_NUM_STRAPS-1:0] strap_pad_oe_n_o,
  input wire logic [SPFM_NUM_STRAPS-1:0] strap_pull_up_o,
  input wire logic [SPFM_NUM_STRAPS-1:0] strap_pull_down_o,
  input wire logic strap_done_o,
  input wire logic sdio_pad_1v8_o,
  input wire logic host_sdio_sel_o,
  input wire logic [SPFM_NUM_PADS-1:0] pad_out_o,
  input wire logic [SPFM_NUM_PADS-1:0] pad_oe_n_o,
  input wire logic coex_radio_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] por_cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // ****************************************
  // Cycles since power-on released
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i || !ext_por_n_i)
      por_cnt <= 32'h0;
    else if (por_cnt != 32'hffff_ffff)
      por_cnt <= por_cnt + 32'h1;
  end
  property p_pull_on;
    !strap_done_o |-> strap_pull_up_o == STRAP_PULL_UP && strap_pull_down_o == STRAP_PULL_DN;
  endproperty
  a_pull_on: assert property (p_pull_on)
    else $error("pulls off while sampling");
  property p_pull_off;
    strap_done_o |-> strap_pull_up_o == 2'h0 && strap_pull_down_o == 2'h0;
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pulls left on");
  property p_strap_float;
    !strap_done_o |-> strap_pad_oe_n_o == 2'h3;
  endproperty
  a_strap_float: assert property (p_strap_float)
    else $error("strap pad driven early");
  property p_hold;
    strap_done_o && $past(strap_done_o) |-> $stable(sdio_pad_1v8_o) && $stable(host_sdio_sel_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("strap modes moved");
  property p_early;
    $rose(strap_done_o) |-> por_cnt >= STRAP_DELAY_CYCLES;
  endproperty
  a_early: assert property (p_early)
    else $error("capture too early");
  property p_late;
    por_cnt == STRAP_DELAY_CYCLES + 8 |-> strap_done_o;
  endproperty
  a_late: assert property (p_late)
    else $error("capture missing");
  property p_radio;
    $past(resetn_i) |-> coex_radio_active_o ==
      ($past(core_out_i.radio_rx_slot) | $past(core_out_i.radio_tx_slot));
  endproperty
  a_radio: assert property (p_radio)
    else $error("radio active wrong");
  property p_reserved;
    pad_sel_i[PAD_AUX_5] == 4'h2 |=> pad_oe_n_o[PAD_AUX_5] && !pad_out_o[PAD_AUX_5];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved select drives");
  property p_i2s_master;
    pad_sel_i[PAD_VOICE_DOUT] == SEL_AUDIO_MASTER |=> !pad_oe_n_o[PAD_VOICE_DOUT] &&
      pad_out_o[PAD_VOICE_DOUT] == $past(core_out_i.audio_master_data_out);
  endproperty
  a_i2s_master: assert property (p_i2s_master)
    else $error("audio master data wrong");
  property p_flash_cs;
    pad_sel_i[PAD_VOICE_SYNC] == SEL_FLASH |=> !pad_oe_n_o[PAD_VOICE_SYNC] &&
      pad_out_o[PAD_VOICE_SYNC] == $past(core_out_i.flash_chip_select_n);
  endproperty
  a_flash_cs: assert property (p_flash_cs)
    else $error("flash select wrong");
  c_capture: cover property ($rose(strap_done_o));
  c_flash: cover property (pad_sel_i[PAD_VOICE_SYNC] == SEL_FLASH);
  c_radio: cover property (coex_radio_active_o);
endmodule
bind spfm_top spfm_top_checker #(.STRAP_DELAY_CYCLES(STRAP_DELAY_CYCLES)) u_chk (
  .clk_sys_i, .resetn_i, .ext_por_n_i, .pad_sel_i, .core_out_i, .strap_pad_oe_n_o,
  .strap_pull_up_o, .strap_pull_down_o, .strap_done_o, .sdio_pad_1v8_o, .host_sdio_sel_o,
  .pad_out_o, .pad_oe_n_o, .coex_radio_active_o);

/* tb/tb.sv */
module tb
  import spfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 8;
  logic clk_sys_i, resetn_i, ext_por_n_i, done, v18, sdio, radio;
  logic [SPFM_NUM_PADS-1:0][SPFM_SEL_W-1:0] pad_sel_i;
  spfm_core_out_t core_out_i;
  spfm_core_in_t core_in_o;
  logic [SPFM_NUM_PADS-1:0] pad_in, pad_out, pad_oe_n, ext_en, ext_val;
  logic [1:0] s_in, s_out, s_oe_n, pull_up, pull_dn, s_en, s_val;
  int n_fail, total_checks, cycles;
  spfm_top #(.STRAP_DELAY_CYCLES(N)) u_dut (.clk_sys_i, .resetn_i, .ext_por_n_i,
    .strap_pad_in_i(s_in), .pad_in_i(pad_in), .pad_sel_i, .core_out_i, .strap_pad_out_o(s_out),
    .strap_pad_oe_n_o(s_oe_n), .strap_pull_up_o(pull_up), .strap_pull_down_o(pull_dn),
    .strap_done_o(done), .sdio_pad_1v8_o(v18), .host_sdio_sel_o(sdio), .pad_out_o(pad_out),
    .pad_oe_n_o(pad_oe_n), .core_in_o, .coex_radio_active_o(radio));
  spfm_board u_board (.clk_sys_i, .pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .strap_out_i(s_out), .strap_oe_n_i(s_oe_n),
    .pull_up_i(pull_up), .pull_dn_i(pull_dn), .strap_en_i(s_en), .strap_val_i(s_val),
    .pad_lvl_o(pad_in), .strap_lvl_o(s_in));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_of_test();
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk_pad(input int p, input logic [3:0] s, input logic [1:0] e);
    @(posedge clk_sys_i);
    pad_sel_i[p] <= s;
    tick(2);
    chk(32'(pad_out[p]), 32'(e[1]));
    chk(32'(pad_oe_n[p]), 32'(e[0]));
  endtask
  task automatic drive(input int p, input logic [3:0] s, input logic v);
    @(posedge clk_sys_i);
    pad_sel_i[p] <= s;
    ext_en[p] <= 1'h1;
    ext_val[p] <= v;
    tick(5);
  endtask
  task automatic por_cycle();
    @(posedge clk_sys_i);
    ext_por_n_i <= 1'h0;
    tick(3);
    ext_por_n_i <= 1'h1;
    tick(N);
    chk(32'(done), 32'h0);
    for (int i = 0; i < 20 && done !== 1'h1; i++)
      tick(1);
    chk(32'(done), 32'h1);
  endtask
  initial
  begin
    clk_sys_i = 1'h0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    cycles = 0;
    resetn_i = 1'h0;
    ext_por_n_i = 1'h0;
    pad_sel_i = '0;
    ext_en = '0;
    ext_val = '0;
    s_en = 2'h0;
    s_val = 2'h0;
    core_out_i = '{gpio_o: 8'h96, agpio_o: 8'h69, strap_gpio_oe_n: 2'h3, prio_status: 1'h1,
      audio_master_bit_clock: 1'h1, audio_slave_data_out: 1'h1, flash_chip_select_n: 1'h1,
      voice_out: 1'h1, voice_sync: 1'h1, shared_clock_request: 1'h1, default: '0};
    tick(4);
    resetn_i <= 1'h1;
    chk(32'({pull_up, pull_dn}), 32'h6);
    por_cycle();
    chk(32'({v18, sdio}), 32'h2);
    chk(32'({pull_up, pull_dn, s_oe_n}), 32'h3);
    s_en <= 2'h3;
    s_val <= 2'h2;
    por_cycle();
    chk(32'({v18, sdio}), 32'h1);
    s_val <= 2'h1;
    tick(6);
    chk(32'({v18, sdio}), 32'h1);
    chk(32'(core_in_o.strap_gpio_i), 32'h1);
    core_out_i.strap_gpio_oe_n <= 2'h0;
    core_out_i.strap_gpio_o <= 2'h2;
    tick(2);
    chk(32'({s_out, s_oe_n}), 32'h8);
    chk_pad(PAD_SERIAL_RTS, 4'h0, 2'h0);
    chk_pad(PAD_SERIAL_RTS, 4'h7, 2'h2);
    chk_pad(PAD_SERIAL_TX, 4'h0, 2'h0);
    chk_pad(PAD_SERIAL_TX, 4'h7, 2'h2);
    chk_pad(PAD_VOICE_DOUT, 4'h0, 2'h0);
    chk_pad(PAD_VOICE_DOUT, 4'h1, 2'h2);
    chk_pad(PAD_VOICE_DOUT, 4'h5, 2'h0);
    chk_pad(PAD_VOICE_DOUT, 4'h7, 2'h2);
    chk_pad(PAD_VOICE_DOUT, 4'hf, 2'h0);
    chk_pad(PAD_VOICE_SYNC, 4'hf, 2'h2);
    chk_pad(PAD_VOICE_CLK, 4'hf, 2'h0);
    chk_pad(PAD_VOICE_CLK, 4'h5, 2'h2);
    chk_pad(PAD_AUX_4, 4'h0, 2'h2);
    chk_pad(PAD_AUX_4, 4'h3, 2'h0);
    chk_pad(PAD_AUX_4, 4'h4, 2'h2);
    chk_pad(PAD_AUX_5, 4'h7, 2'h2);
    chk(32'({pad_out[PAD_AUX_4], pad_oe_n[PAD_AUX_4]}), 32'h2);
    chk_pad(PAD_CLOCK_REQ, 4'h0, 2'h2);
    chk_pad(PAD_CLOCK_REQ, 4'h7, 2'h0);
    chk_pad(PAD_AUDIO_DOUT, 4'h7, 2'h2);
    chk_pad(PAD_AUX_5, 4'h2, 2'h1);
    chk_pad(PAD_SERIAL_CTS, 4'h6, 2'h1);
    chk_pad(PAD_VOICE_SYNC, 4'h1, 2'h3);
    drive(PAD_VOICE_SYNC, 4'h1, 1'h1);
    chk(32'(core_in_o.voice_sync), 32'h1);
    core_out_i.voice_master <= 1'h1;
    tick(2);
    chk(32'({pad_out[PAD_VOICE_SYNC], pad_oe_n[PAD_VOICE_SYNC]}), 32'h2);
    drive(PAD_SERIAL_RX, 4'h0, 1'h0);
    chk(32'(core_in_o.serial_rx), 32'h0);
    drive(PAD_AUDIO_DIN, 4'h7, 1'h1);
    chk(32'(core_in_o.coex_transmit_grant), 32'h1);
    drive(PAD_VOICE_DIN, 4'hf, 1'h1);
    chk(32'(core_in_o.flash_data_in), 32'h1);
    drive(PAD_AUDIO_DIN, 4'h4, 1'h1);
    chk(32'(core_in_o.audio_shared_data_in), 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_i);
      {core_out_i.radio_tx_slot, core_out_i.radio_rx_slot} <= 2'(i);
      tick(2);
      chk(32'(radio), 32'(i != 0));
    end
    end_of_test();
  end
endmodule
